// >>> logic/ltes_pkg.sv
// shared constants, register map and carrier types of the low-temperature stamp bank
package ltes_pkg;

    // ********************************************************************
    // widths
    // ********************************************************************
    localparam int unsigned LTES_AW = 8;
    localparam int unsigned LTES_DW = 8;
    localparam int unsigned LTES_CNT_W = 8;
    localparam int unsigned LTES_SEC_W = 7;

    // ********************************************************************
    // register offsets
    // ********************************************************************
    localparam logic [7:0] LTES_OFS_COUNT = 8'h18;
    localparam logic [7:0] LTES_OFS_SECONDS = 8'h19;
    localparam logic [7:0] LTES_OFS_GROUP_LAST = 8'h1e;
    localparam logic [7:0] LTES_OFS_CTRL = 8'h1f;

    // ********************************************************************
    // control register fields
    // ********************************************************************
    localparam int unsigned LTES_CTRL_EN_BIT = 0;
    localparam int unsigned LTES_CTRL_OVR_BIT = 1;
    localparam int unsigned LTES_CTRL_CLR_BIT = 2;
    localparam int unsigned LTES_CTRL_HELD_BIT = 3;

    // ********************************************************************
    // reset values and the count step
    // ********************************************************************
    localparam logic [7:0] LTES_COUNT_RST = 8'h00;
    localparam logic [6:0] LTES_SECONDS_RST = 7'h00;
    localparam logic LTES_EN_RST = 1'b0;
    localparam logic LTES_OVR_RST = 1'b0;
    localparam logic [7:0] LTES_RDATA_RST = 8'h00;
    localparam logic [7:0] LTES_COUNT_ONE = 8'h01;

    // ********************************************************************
    // types
    // ********************************************************************
    typedef enum logic [0:0] {
        LTES_ARMED = 1'b0,
        LTES_HELD = 1'b1
    } ltes_stamp_st_t;

    typedef struct packed {
        ltes_stamp_st_t st;
        logic [7:0] count;
        logic [6:0] secs;
    } ltes_core_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ltes_bus_req_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic rvalid;
    } ltes_bus_rsp_t;

    typedef struct packed {
        logic en;
        logic ovr;
        ltes_bus_rsp_t rsp;
    } ltes_top_t;

endpackage

// >>> logic/ltes_regs.sv
// register bank holding the low-temperature event count and seconds stamp
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps

// Function
// - the stamp group spans seven registers, counter first, then seconds up to year
// - counter holds number of events where integer temperature is below threshold
// - counter is 8-bit unsigned binary, zero through 255
// - both stamp registers are read-only; writes change nothing
// - seconds stamp holds clock seconds captured at an event, 00 to 59
// - seconds stamp is two bcd digits, tens upper, units in low nibble
// - top bit of the seconds stamp always reads zero
module ltes_regs (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // register port
    input wire ltes_pkg::ltes_bus_req_t bus_req_i,
    output ltes_pkg::ltes_bus_rsp_t bus_rsp_o,
    // from the threshold comparator and the clock, same clock domain
    input wire logic low_event_i,
    input wire logic [ltes_pkg::LTES_SEC_W-1:0] seconds_bcd_i,
    // control and state towards the rest of the unit
    output logic low_stamp_enable_bit_o,
    output logic low_event_override_flag_o,
    output logic low_stamp_held_o,
    output logic low_stamp_clear_bit_o
);
    import ltes_pkg::*;

    // ********************************************************************
    // decode helpers
    // ********************************************************************

    // address match, used by both the write and the read path
    function automatic logic ltes_hit(input logic [7:0] addr, input logic [7:0] ofs);
        ltes_hit = (addr == ofs);
    endfunction

    // inside the seven-register stamp group
    function automatic logic ltes_in_group(input logic [7:0] addr);
        ltes_in_group = (addr >= LTES_OFS_COUNT) && (addr <= LTES_OFS_GROUP_LAST);
    endfunction

    // ********************************************************************
    // state
    // ********************************************************************
    ltes_top_t top_q;
    ltes_top_t top_d;
    ltes_core_t core;
    logic clear_wr;
    logic [7:0] rd_mux;

    // the clear bit is a write-one strobe; it is never stored, so it reads zero
    assign clear_wr = bus_req_i.wr && ltes_hit(bus_req_i.addr, LTES_OFS_CTRL)
                      && bus_req_i.wdata[LTES_CTRL_CLR_BIT];

    // ********************************************************************
    // stamp core
    // ********************************************************************
    ltes_stamp_core u_core (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .low_event_i(low_event_i),
        .enable_i(top_q.en),
        .override_i(top_q.ovr),
        .clear_i(clear_wr),
        .seconds_bcd_i(seconds_bcd_i),
        .core_o(core)
    );

    // ********************************************************************
    // read multiplexer
    // ********************************************************************

    // the five calendar stamps past seconds live elsewhere and read as zero here
    always_comb begin
        rd_mux = LTES_RDATA_RST;
        if (ltes_hit(bus_req_i.addr, LTES_OFS_COUNT)) begin
            rd_mux = core.count;
        end else if (ltes_hit(bus_req_i.addr, LTES_OFS_SECONDS)) begin
            rd_mux = {1'b0, core.secs};
        end else if (ltes_in_group(bus_req_i.addr)) begin
            rd_mux = LTES_RDATA_RST;
        end else if (ltes_hit(bus_req_i.addr, LTES_OFS_CTRL)) begin
            rd_mux = LTES_RDATA_RST;
            rd_mux[LTES_CTRL_EN_BIT] = top_q.en;
            rd_mux[LTES_CTRL_OVR_BIT] = top_q.ovr;
            rd_mux[LTES_CTRL_HELD_BIT] = (core.st == LTES_HELD);
        end
    end

    // ********************************************************************
    // next state of the bank
    // ********************************************************************

    // writes to the count and seconds offsets fall through and touch nothing
    always_comb begin
        top_d = top_q;
        top_d.rsp.rvalid = bus_req_i.rd;
        // data stands one cycle only, zero otherwise
        top_d.rsp.rdata = bus_req_i.rd ? rd_mux : LTES_RDATA_RST;
        if (bus_req_i.wr && ltes_hit(bus_req_i.addr, LTES_OFS_CTRL)) begin
            top_d.en = bus_req_i.wdata[LTES_CTRL_EN_BIT];
            top_d.ovr = bus_req_i.wdata[LTES_CTRL_OVR_BIT];
        end
        // no assignment path exists from the bus into the stamps
    end

    // ********************************************************************
    // registers
    // ********************************************************************
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            top_q.en <= LTES_EN_RST;
            top_q.ovr <= LTES_OVR_RST;
            top_q.rsp.rdata <= LTES_RDATA_RST;
            top_q.rsp.rvalid <= 1'b0;
        end else begin
            top_q <= top_d;
        end
    end

    // ********************************************************************
    // outputs
    // ********************************************************************
    assign bus_rsp_o = top_q.rsp;
    assign low_stamp_enable_bit_o = top_q.en;
    assign low_event_override_flag_o = top_q.ovr;
    assign low_stamp_held_o = (core.st == LTES_HELD);
    // combinational strobe so the unit sees the clear in the write cycle
    assign low_stamp_clear_bit_o = clear_wr;

    // ********************************************************************
    // checks
    // ********************************************************************

    // counting event raises the count by exactly one
    count_step_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (low_event_i && top_q.en && !clear_wr)
        |=> (core.count == 8'($past(core.count) + 8'h01))
    ) else $error("count did not step by one on an event");

    // the top value rolls over to zero
    count_wrap_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (low_event_i && top_q.en && !clear_wr && core.count == 8'hff)
        |=> (core.count == 8'h00)
    ) else $error("count did not wrap from 255 to 0");

    // disabled or quiet cycles leave the count alone
    count_hold_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (!clear_wr && !(low_event_i && top_q.en)) |=> $stable(core.count)
    ) else $error("count moved without a counted event");

    // a write to a stamp register changes neither stamp
    ro_write_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (bus_req_i.wr && ltes_in_group(bus_req_i.addr) && !low_event_i)
        |=> ($stable(core.count) && $stable(core.secs))
    ) else $error("stamp changed after a bus write");

    // a capture takes the clock seconds as they were
    sec_capture_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (low_event_i && top_q.en && (top_q.ovr || core.st == LTES_ARMED || clear_wr))
        |=> (core.secs == $past(seconds_bcd_i) && core.st == LTES_HELD)
    ) else $error("seconds stamp not captured on event");

    // first-event mode keeps the earlier stamp
    sec_keep_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (core.st == LTES_HELD && !top_q.ovr && !clear_wr) |=> $stable(core.secs)
    ) else $error("held seconds stamp overwritten");

    // seconds read shows a clear top bit and the stamp below
    sec_read_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (bus_req_i.rd && ltes_hit(bus_req_i.addr, LTES_OFS_SECONDS))
        |=> (bus_rsp_o.rvalid && !bus_rsp_o.rdata[7]
             && bus_rsp_o.rdata[6:0] == $past(core.secs))
    ) else $error("seconds read data wrong");

    // count read returns the count of the read cycle
    count_read_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (bus_req_i.rd && ltes_hit(bus_req_i.addr, LTES_OFS_COUNT))
        |=> (bus_rsp_o.rdata == $past(core.count))
    ) else $error("count read data wrong");

    // clear alone zeroes both stamps and rearms capture
    clear_zero_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (clear_wr && !low_event_i)
        |=> (core.count == 8'h00 && core.secs == 7'h00 && core.st == LTES_ARMED)
    ) else $error("clear did not zero the stamps");

    // read data only in the cycle after a read
    read_once_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        !bus_req_i.rd |=> (!bus_rsp_o.rvalid && bus_rsp_o.rdata == 8'h00)
    ) else $error("read data outside its cycle");

    // ********************************************************************
    // checks on the control word, the read path and the held state
    // ********************************************************************

    // every read strobe is answered in the next cycle
    read_valid_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        bus_req_i.rd |=> bus_rsp_o.rvalid
    ) else $error("read strobe not answered");

    // the calendar places past seconds read as zero in this bank
    group_read_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (bus_req_i.rd && ltes_in_group(bus_req_i.addr)
         && !ltes_hit(bus_req_i.addr, LTES_OFS_COUNT)
         && !ltes_hit(bus_req_i.addr, LTES_OFS_SECONDS))
        |=> (bus_rsp_o.rdata == 8'h00)
    ) else $error("calendar stamp place did not read zero");

    // places outside the group and the control word read as zero
    unmapped_read_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (bus_req_i.rd && !ltes_in_group(bus_req_i.addr)
         && !ltes_hit(bus_req_i.addr, LTES_OFS_CTRL))
        |=> (bus_rsp_o.rdata == 8'h00)
    ) else $error("unmapped place did not read zero");

    // control read shows enable, override and held, never the clear strobe
    ctrl_read_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (bus_req_i.rd && ltes_hit(bus_req_i.addr, LTES_OFS_CTRL))
        |=> (bus_rsp_o.rdata == {4'h0, $past(low_stamp_held_o), 1'b0,
                                 $past(low_event_override_flag_o), $past(low_stamp_enable_bit_o)})
    ) else $error("control read data wrong");

    // a control write lands in the next cycle
    ctrl_write_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (bus_req_i.wr && ltes_hit(bus_req_i.addr, LTES_OFS_CTRL))
        |=> (top_q.en == $past(bus_req_i.wdata[LTES_CTRL_EN_BIT])
             && top_q.ovr == $past(bus_req_i.wdata[LTES_CTRL_OVR_BIT]))
    ) else $error("control write did not land");

    // without a control write the enable and override bits hold
    ctrl_hold_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        !(bus_req_i.wr && ltes_hit(bus_req_i.addr, LTES_OFS_CTRL))
        |=> ($stable(top_q.en) && $stable(top_q.ovr))
    ) else $error("control bits moved without a write");

    // events while disabled leave count, stamp and held state alone
    event_off_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (low_event_i && !top_q.en && !clear_wr)
        |=> ($stable(core.count) && $stable(core.secs) && $stable(core.st))
    ) else $error("disabled event changed the stamps");

    // counting goes on while a first stamp is held
    held_count_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (low_event_i && top_q.en && !top_q.ovr && !clear_wr && core.st == LTES_HELD)
        |=> (core.count == 8'($past(core.count) + 8'h01) && $stable(core.secs))
    ) else $error("held stamp stopped the count");

    // any counted event leaves a stamp held
    held_set_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (low_event_i && top_q.en) |=> low_stamp_held_o
    ) else $error("no stamp held after an event");

    // the held state only rises through a counted event
    held_rise_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        $rose(low_stamp_held_o) |-> ($past(low_event_i) && $past(top_q.en))
    ) else $error("held state rose without an event");

    // with no clear and no counted event the stamp and its state hold
    sec_idle_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (!clear_wr && !(low_event_i && top_q.en))
        |=> ($stable(core.secs) && $stable(core.st))
    ) else $error("seconds stamp moved without an event");

    // the block does not check its seconds input, so this holds only for a legal clock
    sec_bcd_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (core.secs[3:0] <= 4'h9) && (core.secs[6:4] <= 3'h5)
    ) else $error("seconds stamp is not legal bcd");

    // an event in the clear cycle counts as the first event after the clear
    clear_event_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (clear_wr && low_event_i && top_q.en)
        |=> (core.count == 8'h01 && core.secs == $past(seconds_bcd_i))
    ) else $error("event lost in the clear cycle");

    // a write is never answered with read data
    write_quiet_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        bus_req_i.wr |=> (!bus_rsp_o.rvalid && bus_rsp_o.rdata == 8'h00)
    ) else $error("write produced read data");

endmodule // ltes_regs

// >>> logic/ltes_stamp_core.sv
// event counter and seconds capture of the low-temperature stamp bank
`timescale 1ns/1ps
module ltes_stamp_core (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // events and controls
    input wire logic low_event_i,
    input wire logic enable_i,
    input wire logic override_i,
    input wire logic clear_i,
    // current seconds in bcd
    input wire logic [ltes_pkg::LTES_SEC_W-1:0] seconds_bcd_i,
    // stamp state
    output ltes_pkg::ltes_core_t core_o
);
    import ltes_pkg::*;

    ltes_core_t core_q;
    ltes_core_t core_d;
    logic take_stamp;
    logic [7:0] count_base;

    // next state; an event in the clear cycle survives the clear
    always_comb begin
        core_d = core_q;
        take_stamp = 1'b0;
        count_base = clear_i ? LTES_COUNT_RST : core_q.count;
        case (core_q.st)
            LTES_ARMED: take_stamp = 1'b1;
            LTES_HELD: take_stamp = override_i || clear_i;
            default: take_stamp = 1'b1;
        endcase
        if (clear_i) begin
            core_d.count = LTES_COUNT_RST;
            core_d.secs = LTES_SECONDS_RST;
            core_d.st = LTES_ARMED;
        end
        if (low_event_i && enable_i) begin
            // plain 8-bit add wraps 255 back to 0
            core_d.count = count_base + LTES_COUNT_ONE;
            if (take_stamp) begin
                core_d.secs = seconds_bcd_i;
                core_d.st = LTES_HELD;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            core_q <= '{st: LTES_ARMED, count: LTES_COUNT_RST, secs: LTES_SECONDS_RST};
        end else begin
            core_q <= core_d;
        end
    end

    assign core_o = core_q;

endmodule // ltes_stamp_core

// >>> verif/ltes_secs_model.sv
// partner model: the unit's seconds clock, counting in bcd from 00 to 59
`timescale 1ns/1ps
module ltes_secs_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // advance by one second
    input wire logic step_i,
    // seconds in bcd
    output logic [6:0] seconds_bcd_o
);
    logic [6:0] secs_q;
    // units roll at 9 and tens at 5, so only legal bcd values ever leave the model
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            secs_q <= 7'h00;
        end else if (step_i) begin
            if (secs_q[3:0] != 4'h9) secs_q <= secs_q + 7'h01;
            else if (secs_q[6:4] != 3'h5) secs_q <= {secs_q[6:4] + 3'h1, 4'h0};
            else secs_q <= 7'h00;
        end
    end
    assign seconds_bcd_o = secs_q;
endmodule // ltes_secs_model

// >>> verif/tb.sv
// self-checking bench of the low-temperature stamp register bank
`timescale 1ns/1ps
module tb;
    import ltes_pkg::*;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    ltes_bus_req_t req = '0;
    ltes_bus_rsp_t rsp;
    logic ev = 1'b0;
    logic step = 1'b0;
    logic [6:0] secs;
    logic en_o, ovr_o, held_o, clr_o;
    int errors = 0;
    int comparisons = 0;
    logic [7:0] m_cnt, exp_rd;
    logic [6:0] m_sec;
    logic m_en, m_ovr, m_held, pend;

    // ****************************************
    // clock, design and partner
    // ****************************************
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    ltes_regs uut (.clk_i(clk_i), .resetn_i(resetn_i), .bus_req_i(req), .bus_rsp_o(rsp),
        .low_event_i(ev), .seconds_bcd_i(secs), .low_stamp_enable_bit_o(en_o),
        .low_event_override_flag_o(ovr_o), .low_stamp_held_o(held_o),
        .low_stamp_clear_bit_o(clr_o));
    ltes_secs_model model (.clk_i(clk_i), .resetn_i(resetn_i), .step_i(step),
        .seconds_bcd_o(secs));

    // ****************************************
    // reference model and checks
    // ****************************************
    function automatic logic wr_ctrl();
        return req.wr && req.addr == LTES_OFS_CTRL;
    endfunction
    function automatic logic [7:0] rd_val(input logic [7:0] a);
        case (a)
            LTES_OFS_COUNT: return m_cnt;
            LTES_OFS_SECONDS: return {1'b0, m_sec};
            LTES_OFS_CTRL: return {4'h0, m_held, 1'b0, m_ovr, m_en};
            default: return 8'h00;
        endcase
    endfunction
    // read answers the value before the edge; clear first so a same-cycle event wins
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {m_cnt, m_sec, m_en, m_ovr, m_held, pend} = '0;
        end else begin
            pend = req.rd;
            exp_rd = rd_val(req.addr);
            if (wr_ctrl() && req.wdata[2]) {m_cnt, m_sec, m_held} = '0;
            if (ev && m_en) begin
                m_cnt = m_cnt + 8'h01;
                if (!m_held || m_ovr) m_sec = secs;
                m_held = 1'b1;
            end
            if (wr_ctrl()) {m_ovr, m_en} = req.wdata[1:0];
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask
    // outputs are settled mid-cycle, away from the launching edge
    always @(negedge clk_i) begin
        chk(8'(rsp.rvalid), 8'(pend), "read valid");
        chk(rsp.rdata, pend ? exp_rd : 8'h00, "read data");
        chk(8'({en_o, ovr_o, held_o}), 8'({m_en, m_ovr, m_held}), "control state");
        chk(8'(clr_o), 8'(wr_ctrl() && req.wdata[2]), "clear pulse");
    end

    // ****************************************
    // stimulus
    // ****************************************
    task automatic cyc(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r,
        input logic e);
        @(posedge clk_i);
        req <= '{addr: a, wdata: d, wr: w, rd: r};
        ev <= e;
        step <= 1'($urandom % 2);
    endtask
    // mixed traffic; addresses cover the group, control and an unmapped place
    task automatic rnd(input int n);
        int k;
        logic [7:0] a;
        for (int i = 0; i < n; i++) begin
            k = $urandom % 16;
            a = ($urandom % 10 == 0) ? 8'hff : 8'h18 + 8'($urandom % 8);
            if (k < 8) cyc(a, 8'h00, 1'b0, 1'b1, 1'($urandom % 2));
            else if (k < 12) cyc(a, 8'($urandom), 1'b1, 1'b0, 1'($urandom % 2));
            else if (k == 12) cyc(LTES_OFS_CTRL, 8'($urandom % 8), 1'b1, 1'b0, 1'($urandom % 2));
            else cyc(a, 8'h00, 1'b0, 1'b0, 1'($urandom % 2));
        end
    endtask
    task automatic wrap_up();
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        wrap_up();
    end
    initial begin
        void'($urandom(10019));
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        // reset values across the whole map, unmapped places included
        for (int a = 8'h16; a <= 8'h21; a++) cyc(8'(a), 8'h00, 1'b0, 1'b1, 1'b0);
        // disabled events are ignored while writes to read-only places change nothing
        cyc(LTES_OFS_COUNT, 8'hff, 1'b1, 1'b0, 1'b1);
        cyc(LTES_OFS_SECONDS, 8'hff, 1'b1, 1'b0, 1'b1);
        cyc(LTES_OFS_CTRL, 8'h01, 1'b1, 1'b0, 1'b1);
        // events every cycle past the top of the count, first stamp kept
        for (int i = 0; i < 262; i++) cyc(8'h18 + 8'(i % 2), 8'h00, 1'b0, 1'b1, 1'b1);
        // last stamp kept with override, then clear together with an event
        cyc(LTES_OFS_CTRL, 8'h03, 1'b1, 1'b0, 1'b0);
        for (int i = 0; i < 20; i++) cyc(LTES_OFS_SECONDS, 8'h00, 1'b0, 1'b1, 1'b1);
        cyc(LTES_OFS_CTRL, 8'h07, 1'b1, 1'b0, 1'b1);
        cyc(LTES_OFS_COUNT, 8'h00, 1'b0, 1'b1, 1'b0);
        rnd(1500);
        // second reset in mid-run
        @(posedge clk_i);
        req <= '0;
        resetn_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        rnd(1500);
        cyc(8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
        repeat (2) @(posedge clk_i);
        wrap_up();
    end
endmodule // tb
